// ---- cts_bank.sv ----
// Telemetry and status register bank of the converter, read over a serial management link.
//
// Behaviour
// RULE_01: The current reading is two bytes with exponent minus four in bits 15:11 and a mantissa whose top bit is zero.
// RULE_02: Current readings below 1.65 A are reported as a blanked zero.
// RULE_03: Only sourced current is reported; a sinking converter reads zero.
// RULE_04: The current reading is an average, not a single sample.
// RULE_05: The offset trim reads as exponent minus four and a signed 11-bit mantissa of 62.5 mA steps.
// RULE_06: The gain trim is unsigned 16 bits; the reading is raw times gain over 8192 plus offset.
// RULE_07: The current reading is temperature compensated before it is returned.
// RULE_08: The temperature reading is two bytes with exponent minus two and a signed 11-bit mantissa.
// RULE_09: The summary word carries vout, iout, input, power-good-low, off, ov, oc, uv, temp and comm bits.
// RULE_10: Unsupported status bits always read zero and all status bits reset to zero.
// RULE_11: Output voltage status holds only the overvoltage fault in bit 7.
// RULE_12: Output current status holds the overcurrent fault in bit 7 and warning in bit 5.
// RULE_13: Input status holds overvoltage in bit 7, undervoltage in bit 4 and low-input off in bit 3.
// RULE_14: Temperature status holds the overtemperature fault in bit 7 and warning in bit 6.
// RULE_15: Communication status holds bad command in bit 7, bad data in bit 6 and check failure in bit 5.
// RULE_16: Status bits latch until a clear-faults command and summary bits are the OR of their categories.
`default_nettype none
module cts_bank (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Management link pins
  input  wire logic              lk_clk,
  input  wire logic              lk_sel_n,
  input  wire logic              lk_din,
  output var  logic              lk_dout,
  // Measurement samples
  input  wire logic              adc_vld,
  input  wire logic [15:0]       adc_iout,
  input  wire logic [10:0]       adc_temp,
  // Factory trims
  input  wire logic [10:0]       trim_offset,
  input  wire logic [15:0]       trim_gain,
  // Protection conditions
  input  wire cts_pkg::cts_flt_t flt
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [2:0]         s1;
    logic [2:0]         s2;
    logic               ck_prev;
    cts_pkg::cts_fsm_t  fsm;
    logic [4:0]         cnt;
    logic [7:0]         cmd;
    logic [15:0]        sh;
    logic               dout;
    cts_pkg::cts_stat_t stat;
    logic [10:0]        temp;
    logic [15:0]        iout_rd;
  } cts_bank_st_t;

  cts_bank_st_t st_r;
  cts_bank_st_t st_nxt;
  logic         rise;
  logic         fall;
  logic         sel;
  logic         din;
  logic         clr;
  logic         unk;
  logic [7:0]   code;
  logic         iout_vld;
  logic [10:0]  iout_mant;
  logic [7:0]   set_vout;
  logic [7:0]   set_iout;
  logic [7:0]   set_in;
  logic [7:0]   set_temp;
  logic [7:0]   set_cml;

  // ************************************************************
  // Decoding
  // ************************************************************
  function automatic logic cmd_known(input logic [7:0] c);
    unique case (c)
      cts_pkg::CMD_CLEAR_FAULTS, cts_pkg::CMD_STAT_WORD, cts_pkg::CMD_STAT_VOUT,
      cts_pkg::CMD_STAT_IOUT, cts_pkg::CMD_STAT_INPUT, cts_pkg::CMD_STAT_TEMP,
      cts_pkg::CMD_STAT_CML, cts_pkg::CMD_OUTPUT_CURRENT_READING, cts_pkg::CMD_READ_TEMP,
      cts_pkg::CMD_IOUT_OFFSET, cts_pkg::CMD_IOUT_GAIN: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction : cmd_known

  function automatic logic [15:0] status_word(input cts_pkg::cts_stat_t s, input cts_pkg::cts_flt_t f);
    logic [15:0] w;
    w                      = '0;
    w[cts_pkg::SW_VOUT]    = |s.vout; // RULE_16
    w[cts_pkg::SW_IOUT]    = |s.iout;
    w[cts_pkg::SW_INPUT]   = |s.input_s;
    w[cts_pkg::SW_PGOOD_N] = f.pgood_n; // RULE_09
    w[cts_pkg::SW_OFF]     = f.unit_off;
    w[cts_pkg::SW_VOUT_OV] = s.vout[cts_pkg::B_VO_OV];
    w[cts_pkg::SW_IOUT_OC] = s.iout[cts_pkg::B_IO_OC];
    w[cts_pkg::SW_VIN_UV]  = s.input_s[cts_pkg::B_IN_UV];
    w[cts_pkg::SW_TEMP]    = |s.temp;
    w[cts_pkg::SW_CML]     = |s.cml;
    status_word            = w & cts_pkg::MASK_WORD; // RULE_10
  endfunction : status_word

  // Data goes out low byte first; single-byte answers fill the second byte with zeros.
  function automatic logic [15:0] resp_load(input logic [15:0] w);
    resp_load = {w[7:0], w[15:8]};
  endfunction : resp_load

  // ************************************************************
  // Current processing
  // ************************************************************
  cts_iout_proc #(
    .TREF   (cts_pkg::TREF_MANT),
    .TC_SH  (cts_pkg::TC_SHIFT),
    .AVG_SH (cts_pkg::AVG_SHIFT),
    .W      (24)
  ) u_proc (
    .clk       (clk),
    .rstn      (rstn),
    .smp_vld   (adc_vld),
    .raw       (adc_iout),
    .temp_mant (adc_temp),
    .gain      (trim_gain),
    .offset    (trim_offset),
    .out_vld   (iout_vld),
    .mant      (iout_mant)
  );

  // ************************************************************
  // Link framing and status latches
  // ************************************************************
  always_comb begin
    st_nxt         = st_r;
    st_nxt.s1      = {lk_clk, lk_sel_n, lk_din};
    st_nxt.s2      = st_r.s1;
    st_nxt.ck_prev = st_r.s2[2];
    rise           = st_r.s2[2] & ~st_r.ck_prev;
    fall           = ~st_r.s2[2] & st_r.ck_prev;
    sel            = ~st_r.s2[1];
    din            = st_r.s2[0];
    code           = {st_r.cmd[6:0], din};
    clr            = 1'b0;
    unk            = 1'b0;
    unique case (st_r.fsm)
      cts_pkg::ST_IDLE: begin
        if (sel) begin
          st_nxt.fsm = cts_pkg::ST_CMD;
          st_nxt.cnt = '0;
        end
      end
      cts_pkg::ST_CMD: begin
        if (rise) begin
          st_nxt.cmd = code;
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == cts_pkg::CMD_BITS - 5'h01) begin
            st_nxt.fsm = cts_pkg::ST_RESP;
            unk        = ~cmd_known(code); // RULE_15
            clr        = (code == cts_pkg::CMD_CLEAR_FAULTS); // RULE_16
            unique case (code)
              cts_pkg::CMD_STAT_WORD:   st_nxt.sh = resp_load(status_word(st_r.stat, flt)); // RULE_09
              cts_pkg::CMD_STAT_VOUT:   st_nxt.sh = {st_r.stat.vout, 8'h00};
              cts_pkg::CMD_STAT_IOUT:   st_nxt.sh = {st_r.stat.iout, 8'h00};
              cts_pkg::CMD_STAT_INPUT:  st_nxt.sh = {st_r.stat.input_s, 8'h00};
              cts_pkg::CMD_STAT_TEMP:   st_nxt.sh = {st_r.stat.temp, 8'h00};
              cts_pkg::CMD_STAT_CML:    st_nxt.sh = {st_r.stat.cml, 8'h00};
              cts_pkg::CMD_OUTPUT_CURRENT_READING:   st_nxt.sh = resp_load(st_r.iout_rd);
              cts_pkg::CMD_READ_TEMP:   st_nxt.sh = resp_load({cts_pkg::EXP_TEMP, st_r.temp}); // RULE_08
              cts_pkg::CMD_IOUT_OFFSET: st_nxt.sh = resp_load({cts_pkg::EXP_TRIM, trim_offset}); // RULE_05
              cts_pkg::CMD_IOUT_GAIN:   st_nxt.sh = resp_load(trim_gain); // RULE_06
              default:                  st_nxt.sh = '0;
            endcase
          end
        end
      end
      cts_pkg::ST_RESP: begin
        if (fall) begin
          st_nxt.dout = st_r.sh[15];
          st_nxt.sh   = {st_r.sh[14:0], 1'b0};
        end
      end
      default: begin
        st_nxt.fsm = cts_pkg::ST_IDLE;
      end
    endcase
    // Dropping the select ends the frame at once, whatever bit it was on.
    if (!sel) begin
      st_nxt.fsm  = cts_pkg::ST_IDLE;
      st_nxt.dout = 1'b0;
    end

    set_vout                       = '0;
    set_iout                       = '0;
    set_in                         = '0;
    set_temp                       = '0;
    set_cml                        = '0;
    set_vout[cts_pkg::B_VO_OV]     = flt.vout_ov; // RULE_11
    set_iout[cts_pkg::B_IO_OC]     = flt.iout_oc; // RULE_12
    set_iout[cts_pkg::B_IO_OCW]    = flt.iout_ocw;
    set_in[cts_pkg::B_IN_OV]       = flt.vin_ov; // RULE_13
    set_in[cts_pkg::B_IN_UV]       = flt.vin_uv;
    set_in[cts_pkg::B_IN_LOW]      = flt.vin_low_off;
    set_temp[cts_pkg::B_TP_OT]     = flt.ot_flt; // RULE_14
    set_temp[cts_pkg::B_TP_OTW]    = flt.ot_warn;
    set_cml[cts_pkg::B_CML_CMD]    = unk; // RULE_15
    set_cml[cts_pkg::B_CML_DATA]   = flt.bad_data;
    set_cml[cts_pkg::B_CML_PEC]    = flt.pec_fail;
    // A condition present in the clearing cycle stays latched, so no event slips through a clear.
    st_nxt.stat.vout    = ((clr ? 8'h00 : st_r.stat.vout) | set_vout) & cts_pkg::MASK_VOUT; // RULE_16
    st_nxt.stat.iout    = ((clr ? 8'h00 : st_r.stat.iout) | set_iout) & cts_pkg::MASK_IOUT; // RULE_16
    st_nxt.stat.input_s = ((clr ? 8'h00 : st_r.stat.input_s) | set_in) & cts_pkg::MASK_INPUT; // RULE_16
    st_nxt.stat.temp    = ((clr ? 8'h00 : st_r.stat.temp) | set_temp) & cts_pkg::MASK_TEMP; // RULE_16
    st_nxt.stat.cml     = ((clr ? 8'h00 : st_r.stat.cml) | set_cml) & cts_pkg::MASK_CML; // RULE_10

    if (iout_vld) begin
      st_nxt.iout_rd = {cts_pkg::EXP_IOUT, iout_mant}; // RULE_01
    end
    if (adc_vld) begin
      st_nxt.temp = adc_temp; // RULE_08
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= '0;
      st_r.fsm <= cts_pkg::ST_IDLE;
      st_r.s1  <= 3'h2;
      st_r.s2  <= 3'h2;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lk_dout = st_r.dout;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_vout_latch:  assert property (flt.vout_ov |=> st_r.stat.vout[cts_pkg::B_VO_OV]) // RULE_11
    else $error("output overvoltage not latched");
  a_iout_latch:  assert property (flt.iout_ocw |=> st_r.stat.iout[cts_pkg::B_IO_OCW]) // RULE_12
    else $error("overcurrent warning not latched");
  a_input_latch: assert property (flt.vin_low_off |=> st_r.stat.input_s[cts_pkg::B_IN_LOW]) // RULE_13
    else $error("low input off not latched");
  a_temp_latch:  assert property (flt.ot_warn |=> st_r.stat.temp[cts_pkg::B_TP_OTW]) // RULE_14
    else $error("overtemperature warning not latched");
  a_bad_cmd:     assert property (unk |=> st_r.stat.cml[cts_pkg::B_CML_CMD] ##1 st_r.stat.cml[cts_pkg::B_CML_CMD]) // RULE_15
    else $error("unknown command not flagged");
  a_fault_hold:  assert property (st_r.stat.temp[cts_pkg::B_TP_OT] && !clr |=> st_r.stat.temp[cts_pkg::B_TP_OT]) // RULE_16
    else $error("latched fault dropped without clear");
  a_clear_all:   assert property (clr && flt == '0 |=> st_r.stat == '0) // RULE_16
    else $error("clear faults left status set");
  a_unsup_zero:  assert property ((st_r.stat.iout & ~cts_pkg::MASK_IOUT) == '0 && (st_r.stat.input_s & ~cts_pkg::MASK_INPUT) == '0) // RULE_10
    else $error("unsupported status bit set");
  a_word_sum:    assert property (rise && st_r.fsm == cts_pkg::ST_CMD && st_r.cnt == 5'h07 && code == cts_pkg::CMD_STAT_WORD |=> st_r.sh[cts_pkg::SW_INPUT - 8] == $past(|st_r.stat.input_s)) // RULE_09
    else $error("summary input bit wrong");
  a_iout_fmt:    assert property (iout_vld |=> st_r.iout_rd[15:11] == cts_pkg::EXP_IOUT && !st_r.iout_rd[10]) // RULE_01
    else $error("current reading format wrong");
  a_temp_fmt:    assert property (adc_vld |=> st_r.temp == $past(adc_temp)) // RULE_08
    else $error("temperature reading not captured");
  a_frame_end:   assert property (!sel |=> st_r.fsm == cts_pkg::ST_IDLE && !lk_dout)
    else $error("frame did not end on deselect");

  c_read_frame:  cover property (st_r.fsm == cts_pkg::ST_CMD && rise && st_r.cnt == 5'h07 && cmd_known(code));
  c_clear:       cover property (clr && st_r.stat != '0);
  c_unknown:     cover property (unk);
  c_iout_live:   cover property (iout_vld && iout_mant != '0);

endmodule : cts_bank
`default_nettype wire

// ---- cts_bank_tb.sv ----
// Self-checking bench of the telemetry and status bank against an integer model.
`default_nettype none
module cts_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              rstn;
  logic              lk_clk;
  logic              lk_sel_n;
  logic              lk_din;
  logic              lk_dout;
  logic              adc_vld;
  logic [15:0]       adc_iout;
  logic [10:0]       adc_temp;
  logic [10:0]       trim_offset;
  logic [15:0]       trim_gain;
  cts_pkg::cts_flt_t flt;
  int                n_fail;
  int                total_checks;
  int                cyc = 0;
  int                pr [5] = '{400, 26, 27, -300, 10};
  int                po [5] = '{0, 0, 0, 0, -20};
  logic [7:0]        bm [5] = '{8'h80, 8'ha0, 8'h98, 8'hc0, 8'he0};
  logic [7:0]        tc [12] = '{8'h61, 8'h62, 8'h62, 8'h63, 8'h63, 8'h63, 8'h64, 8'h64, 8'h00, 8'h00, 8'h65, 8'h65};
  logic [7:0]        tb [12] = '{8'h80, 8'h80, 8'h20, 8'h80, 8'h10, 8'h08, 8'h80, 8'h40, 8'h00, 8'h00, 8'h40, 8'h20};
  logic [15:0]       tw [12] = '{16'h8020, 16'h4010, 16'h4000, 16'h2000, 16'h2008, 16'h2000, 16'h0004, 16'h0004,
                                 16'h0040, 16'h0800, 16'h0002, 16'h0002};

  cts_bank dut (
    .clk         (clk),
    .rstn        (rstn),
    .lk_clk      (lk_clk),
    .lk_sel_n    (lk_sel_n),
    .lk_din      (lk_din),
    .lk_dout     (lk_dout),
    .adc_vld     (adc_vld),
    .adc_iout    (adc_iout),
    .adc_temp    (adc_temp),
    .trim_offset (trim_offset),
    .trim_gain   (trim_gain),
    .flt         (flt)
  );

  cts_host_model host (
    .clk      (clk),
    .lk_clk   (lk_clk),
    .lk_sel_n (lk_sel_n),
    .lk_din   (lk_din),
    .lk_dout  (lk_dout)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end

  // ************************************************************
  // Model and checks
  // ************************************************************
  // Apart from one first sample into a zeroed accumulator, only settled averages are predicted, so the accumulator state matters nowhere else.
  function automatic logic [15:0] iexp(input int raw, input int g, input int o, input int t);
    int c;
    c = ((raw * g) >>> 13) + o;
    c = c + ((c * (t - 100)) >>> 12);
    if (c * 625 < 16500) c = 0;
    if (c > 1023) c = 1023;
    return {5'h1c, 11'(c)};
  endfunction : iexp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: answer %h, model %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] a;
    host.xfer(code, a);
    chk(a, exp);
  endtask : rd

  task automatic smp(input int raw, input int t, input int n);
    repeat (n) begin
      @(posedge clk);
      adc_vld  <= 1'b1;
      adc_iout <= 16'(raw);
      adc_temp <= 11'(t);
      @(posedge clk);
      adc_vld  <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : smp

  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    int i;
    int t;
    int g;
    int o;
    rstn         = 1'b0;
    adc_vld      = 1'b0;
    adc_iout     = 16'h0000;
    adc_temp     = 11'h000;
    trim_offset  = 11'h000;
    trim_gain    = 16'h2000;
    flt          = '0;
    n_fail       = 0;
    total_checks = 0;
    i = $urandom(32'h7b09c1b4);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 6; i++) rd(8'(8'h60 + i), 16'h0000);
    t = int'($urandom_range(2047)) - 1024;
    smp(0, t, 1);
    rd(cts_pkg::CMD_READ_TEMP, {5'h1e, 11'(t)});
    smp(0, 100, 1);
    smp(400, 100, 1);
    rd(cts_pkg::CMD_OUTPUT_CURRENT_READING, iexp(50, 8192, 0, 100));
    for (i = 0; i < 5; i++) begin
      trim_offset <= 11'(po[i]);
      smp(pr[i], 100, 100);
      rd(cts_pkg::CMD_OUTPUT_CURRENT_READING, iexp(pr[i], 8192, po[i], 100));
    end
    g = 7000 + int'($urandom_range(2000));
    o = int'($urandom_range(100)) - 50;
    t = 20 + int'($urandom_range(300));
    trim_gain   <= 16'(g);
    trim_offset <= 11'(o);
    smp(500, t, 100);
    rd(cts_pkg::CMD_OUTPUT_CURRENT_READING, iexp(500, g, o, t));
    rd(cts_pkg::CMD_IOUT_OFFSET, {5'h1c, 11'(o)});
    rd(cts_pkg::CMD_IOUT_GAIN, 16'(g));
    rd(8'ha5, 16'h0000);
    flt <= '1;
    repeat (2) @(posedge clk);
    rd(cts_pkg::CMD_STAT_WORD, 16'he87e);
    for (i = 0; i < 5; i++) rd(8'(8'h61 + i), {8'h00, bm[i]});
    flt <= '0;
    rd(cts_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    rd(cts_pkg::CMD_STAT_WORD, 16'h0000);
    for (i = 0; i < 12; i++) begin
      flt <= cts_pkg::cts_flt_t'(12'h800 >> i);
      repeat (2) @(posedge clk);
      if (tc[i] != 8'h00) flt <= '0;
      rd(cts_pkg::CMD_STAT_WORD, tw[i]);
      if (tc[i] != 8'h00) rd(tc[i], {8'h00, tb[i]});
      flt <= '0;
      rd(cts_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      rd(cts_pkg::CMD_STAT_WORD, 16'h0000);
    end
    final_report();
  end

endmodule : cts_bank_tb
`default_nettype wire

// ---- cts_host_model.sv ----
// Behavioural management host that runs one command frame per call.
`default_nettype none
module cts_host_model (
  // Clock
  input  wire logic clk,
  // Link pins
  output var  logic lk_clk,
  output var  logic lk_sel_n,
  output var  logic lk_din,
  input  wire logic lk_dout
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    lk_clk   = 1'b0;
    lk_sel_n = 1'b1;
    lk_din   = 1'b0;
  end

  // ************************************************************
  // Frame
  // ************************************************************
  // The link clock stands low outside frames. Its low phase is longer than the high phase so that an answer bit,
  // which lags the falling edge by the synchroniser, has settled when the host samples it at its rising edge.
  task automatic xfer(input logic [7:0] code, output logic [15:0] ans);
    int k;
    ans = 16'h0000;
    @(posedge clk);
    lk_sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (k = 0; k < 24; k++) begin
      lk_clk <= 1'b0;
      lk_din <= (k < 8) ? code[7 - k] : ~lk_din;
      repeat (5) @(posedge clk);
      if (k >= 8) ans[(k < 16) ? 15 - k : 31 - k] = lk_dout;
      lk_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    lk_clk <= 1'b0;
    lk_din <= ~lk_din;
    repeat (4) @(posedge clk);
    lk_sel_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : xfer

endmodule : cts_host_model
`default_nettype wire

// ---- cts_iout_proc.sv ----
// Output current correction, temperature compensation, averaging and linear formatting.
`default_nettype none
module cts_iout_proc #(
  parameter int TREF     = cts_pkg::TREF_MANT,
  parameter int TC_SH    = cts_pkg::TC_SHIFT,
  parameter int AVG_SH   = cts_pkg::AVG_SHIFT,
  parameter int W        = 24
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Raw conversion and trims
  input  wire logic        smp_vld,
  input  wire logic [15:0] raw,
  input  wire logic [10:0] temp_mant,
  input  wire logic [15:0] gain,
  input  wire logic [10:0] offset,
  // Formatted mantissa
  output var  logic        out_vld,
  output var  logic [10:0] mant
);

  localparam int ACC_W = W + AVG_SH;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [10:0]      mant;
    logic             vld;
  } cts_proc_st_t;

  cts_proc_st_t            st;
  cts_proc_st_t            nx;
  logic signed [32:0]      scaled;
  logic signed [32:0]      corr;
  logic signed [11:0]      delta;
  logic signed [44:0]      tprod;
  logic signed [32:0]      comp;
  logic signed [ACC_W-1:0] acc_nxt;
  logic signed [ACC_W-1:0] avg;

  always_comb begin
    nx      = st;
    scaled  = ($signed(raw) * $signed({1'b0, gain})) >>> cts_pkg::GAIN_SHIFT; // RULE_06
    corr    = scaled + 33'($signed(offset)); // RULE_06
    delta   = 12'($signed(temp_mant)) - 12'(TREF);
    tprod   = corr * delta;
    comp    = corr + 33'(tprod >>> TC_SH); // RULE_07
    // A running average keeps ripple out of the reading at the cost of a few samples of lag.
    acc_nxt = $signed(st.acc) + ACC_W'($signed(comp[W-1:0])) - ($signed(st.acc) >>> AVG_SH); // RULE_04
    avg     = acc_nxt >>> AVG_SH;
    nx.vld  = smp_vld;
    if (smp_vld) begin
      nx.acc = acc_nxt;
      if (avg < 0) begin
        nx.mant = '0; // RULE_03
      end else if (avg < $signed(ACC_W'(cts_pkg::IOUT_BLANK))) begin
        nx.mant = '0; // RULE_02
      end else if (avg > $signed(ACC_W'(cts_pkg::MANT_POS_MAX))) begin
        nx.mant = cts_pkg::MANT_POS_MAX; // RULE_01
      end else begin
        nx.mant = avg[10:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign out_vld = st.vld;
  assign mant    = st.mant;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_sink_zero:   assert property (smp_vld && avg < 0 |=> mant == '0 && out_vld) // RULE_03
    else $error("sinking current did not read zero");
  a_blank_floor: assert property (mant != '0 |-> mant >= 11'(cts_pkg::IOUT_BLANK)) // RULE_02
    else $error("current reading below blanking level");
  a_mant_top:    assert property (mant[10] == 1'b0) // RULE_01
    else $error("current mantissa top bit set");

endmodule : cts_iout_proc
`default_nettype wire

// ---- cts_pkg.sv ----
// Shared constants, types and command codes of the converter telemetry and status bank.
`default_nettype none
package cts_pkg;

  // ************************************************************
  // Command codes and frame sizes
  // ************************************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STAT_WORD    = 8'h60;
  localparam logic [7:0] CMD_STAT_VOUT    = 8'h61;
  localparam logic [7:0] CMD_STAT_IOUT    = 8'h62;
  localparam logic [7:0] CMD_STAT_INPUT   = 8'h63;
  localparam logic [7:0] CMD_STAT_TEMP    = 8'h64;
  localparam logic [7:0] CMD_STAT_CML     = 8'h65;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_READING    = 8'h66;
  localparam logic [7:0] CMD_READ_TEMP    = 8'h67;
  localparam logic [7:0] CMD_IOUT_OFFSET  = 8'h68;
  localparam logic [7:0] CMD_IOUT_GAIN    = 8'h69;
  localparam logic [4:0] CMD_BITS         = 5'h08;

  // ************************************************************
  // Linear format exponents and measurement scaling
  // ************************************************************
  localparam logic [4:0]  EXP_IOUT      = 5'h1c;
  localparam logic [4:0]  EXP_TEMP      = 5'h1e;
  localparam logic [4:0]  EXP_TRIM      = 5'h1c;
  localparam int          GAIN_SHIFT    = 13;
  localparam int          IOUT_BLANK_MA = 1650;
  localparam int          IOUT_STEP_UA  = 62500;
  localparam int          IOUT_BLANK    = (IOUT_BLANK_MA * 1000 + IOUT_STEP_UA - 1) / IOUT_STEP_UA;
  localparam logic [10:0] MANT_POS_MAX  = 11'h3ff;
  localparam int          TREF_MANT     = 100;
  localparam int          TC_SHIFT      = 12;
  localparam int          AVG_SHIFT     = 3;

  // ************************************************************
  // Status bit positions and supported-bit masks
  // ************************************************************
  localparam int SW_VOUT    = 15;
  localparam int SW_IOUT    = 14;
  localparam int SW_INPUT   = 13;
  localparam int SW_PGOOD_N = 11;
  localparam int SW_OFF     = 6;
  localparam int SW_VOUT_OV = 5;
  localparam int SW_IOUT_OC = 4;
  localparam int SW_VIN_UV  = 3;
  localparam int SW_TEMP    = 2;
  localparam int SW_CML     = 1;
  localparam int B_VO_OV    = 7;
  localparam int B_IO_OC    = 7;
  localparam int B_IO_OCW   = 5;
  localparam int B_IN_OV    = 7;
  localparam int B_IN_UV    = 4;
  localparam int B_IN_LOW   = 3;
  localparam int B_TP_OT    = 7;
  localparam int B_TP_OTW   = 6;
  localparam int B_CML_CMD  = 7;
  localparam int B_CML_DATA = 6;
  localparam int B_CML_PEC  = 5;
  localparam logic [7:0]  MASK_VOUT  = 8'h80;
  localparam logic [7:0]  MASK_IOUT  = 8'ha0;
  localparam logic [7:0]  MASK_INPUT = 8'h98;
  localparam logic [7:0]  MASK_TEMP  = 8'hc0;
  localparam logic [7:0]  MASK_CML   = 8'he0;
  localparam logic [15:0] MASK_WORD  = 16'he87e;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic iout_ocw;
    logic vin_ov;
    logic vin_uv;
    logic vin_low_off;
    logic ot_flt;
    logic ot_warn;
    logic unit_off;
    logic pgood_n;
    logic bad_data;
    logic pec_fail;
  } cts_flt_t;

  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] input_s;
    logic [7:0] temp;
    logic [7:0] cml;
  } cts_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CMD  = 3'h2,
    ST_RESP = 3'h4
  } cts_fsm_t;

endpackage : cts_pkg
`default_nettype wire
